// *** hw/cxa_regs.vh ***
// Register offsets, field positions, reset values and codes of the ALU core
`ifndef CXA_REGS_VH
`define CXA_REGS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define CXA_ADDR_W          4
`define CXA_CORE_CTRL_ADDR  4'h0
`define CXA_FLAGS_ADDR      4'h1
`define CXA_CORE_CTRL_RST   16'h0000
`define CXA_FLAGS_RST       5'h00

// ****************************************************************
// Core control fields
// ****************************************************************
`define CXA_PRIO7_BIT       3
`define CXA_PSWIN_BIT       2

// ****************************************************************
// Arithmetic flag fields
// ****************************************************************
`define CXA_FLAGS_W         5
`define CXA_FL_C            0
`define CXA_FL_Z            1
`define CXA_FL_OV           2
`define CXA_FL_N            3
`define CXA_FL_DC           4

// ****************************************************************
// Operation codes
// ****************************************************************
`define CXA_OP_ADD          4'h0
`define CXA_OP_ADDC         4'h1
`define CXA_OP_SUB          4'h2
`define CXA_OP_SUBB         4'h3
`define CXA_OP_AND          4'h4
`define CXA_OP_IOR          4'h5
`define CXA_OP_XOR          4'h6
`define CXA_OP_COM          4'h7
`define CXA_OP_SL           4'h8
`define CXA_OP_LSR          4'h9
`define CXA_OP_ASR          4'hA
`define CXA_OP_MUL          4'hB
`define CXA_OP_DIV          4'hC

// ****************************************************************
// Multiplier modes
// ****************************************************************
`define CXA_MUL_SS          3'h0
`define CXA_MUL_UU          3'h1
`define CXA_MUL_US          3'h2
`define CXA_MUL_SL5         3'h3
`define CXA_MUL_UL5         3'h4
`define CXA_MUL_BYTE        3'h5

// ****************************************************************
// Timing
// ****************************************************************
`define CXA_DIV_STEPS       5'd16

`endif

// *** hw/cxa_mul17.v ***
// Signed 17x17 multiplier with registered product
`timescale 1ns/1ps
module cxa_mul17 (
    input  wire        i_core_clk,
    input  wire        i_rst_n,
    input  wire [16:0] i_a,
    input  wire [16:0] i_b,
    output reg  [33:0] o_prod
);

    wire signed [33:0] prod_d;

    assign prod_d = $signed(i_a) * $signed(i_b);

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_prod <= 34'h0;
        end else begin
            o_prod <= prod_d;
        end
    end

endmodule

// *** hw/cxa_div16.v ***
// Iterative restoring divider, 16-bit dividend and 16-bit divisor
`timescale 1ns/1ps
`include "cxa_regs.vh"
module cxa_div16 (
    input  wire        i_core_clk,
    input  wire        i_rst_n,
    input  wire        i_start,
    input  wire        i_signed,
    input  wire [15:0] i_dvd,
    input  wire [15:0] i_dvs,
    output wire        o_busy,
    output reg         o_done,
    output reg         o_dz,
    output reg  [15:0] o_quot,
    output reg  [15:0] o_rem
);

    reg  [4:0]  cnt_q;
    reg         busy_q;
    reg  [15:0] quo_q;
    reg  [16:0] rem_q;
    reg  [15:0] dvs_q;
    reg         negq_q;
    reg         negr_q;
    wire [15:0] dvd_abs;
    wire [15:0] dvs_abs;
    wire [16:0] trial;

    assign dvd_abs = (i_signed && i_dvd[15]) ? (16'h0 - i_dvd) : i_dvd;
    assign dvs_abs = (i_signed && i_dvs[15]) ? (16'h0 - i_dvs) : i_dvs;
    assign trial   = {rem_q[15:0], quo_q[15]} - {1'b0, dvs_q};
    assign o_busy  = busy_q;

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cnt_q  <= 5'h0;
            busy_q <= 1'b0;
            quo_q  <= 16'h0;
            rem_q  <= 17'h0;
            dvs_q  <= 16'h0;
            negq_q <= 1'b0;
            negr_q <= 1'b0;
            o_done <= 1'b0;
            o_dz   <= 1'b0;
            o_quot <= 16'h0;
            o_rem  <= 16'h0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !busy_q) begin
                busy_q <= 1'b1;
                cnt_q  <= `CXA_DIV_STEPS;
                quo_q  <= dvd_abs;
                rem_q  <= 17'h0;
                dvs_q  <= dvs_abs;
                negq_q <= i_signed & (i_dvd[15] ^ i_dvs[15]);
                negr_q <= i_signed & i_dvd[15];
                o_dz   <= (i_dvs == 16'h0);
            end else if (busy_q && cnt_q != 5'h0) begin
                cnt_q <= cnt_q - 5'h1;
                if (!trial[16]) begin
                    rem_q <= trial;
                    quo_q <= {quo_q[14:0], 1'b1};
                end else begin
                    rem_q <= {rem_q[15:0], quo_q[15]};
                    quo_q <= {quo_q[14:0], 1'b0};
                end
            end else if (busy_q) begin
                // Sign fix-up after the last step
                busy_q <= 1'b0;
                o_done <= 1'b1;
                o_quot <= negq_q ? (16'h0 - quo_q) : quo_q;
                o_rem  <= negr_q ? (16'h0 - rem_q[15:0]) : rem_q[15:0];
            end
        end
    end

endmodule

// *** hw/cxa_core.v ***
// ALU datapath, multiplier, divider support and core control register
`timescale 1ns/1ps
`include "cxa_regs.vh"

module cxa_core (
    input  wire        i_core_clk,
    input  wire        i_rst_n,
    input  wire [3:0]  i_reg_addr,
    input  wire [15:0] i_reg_wdata,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    output reg  [15:0] o_reg_rdata,
    input  wire [3:0]  i_cpu_prio,
    output wire        o_priority_above_seven,
    output wire        o_user_int_block,
    output wire        o_program_space_window_en,
    input  wire        i_op_valid,
    input  wire [3:0]  i_op_code,
    input  wire        i_byte_mode,
    input  wire [2:0]  i_mul_mode,
    input  wire        i_div_signed,
    input  wire [4:0]  i_lit5,
    input  wire        i_src_a_mem,
    input  wire        i_src_b_mem,
    input  wire        i_dst_mem,
    input  wire [15:0] i_w_rd_a,
    input  wire [15:0] i_w_rd_b,
    input  wire [15:0] i_mem_rd,
    output wire        o_busy,
    output reg         o_res_valid,
    output reg         o_res_w_we,
    output reg         o_res_mem_we,
    output reg  [15:0] o_res_lo,
    output reg  [15:0] o_res_hi,
    output wire [4:0]  o_arith_flags
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg         prio7_q;
    reg         gt7_prev_q;
    reg         pswin_q;
    reg  [4:0]  flags_q;
    reg  [4:0]  flags_d;
    reg         mul_pend_q;
    reg         dst_mem_q;
    reg  [15:0] res_d;
    reg  [16:0] mul_a;
    reg  [16:0] mul_b;
    reg         upd_c;
    reg         upd_ov;
    reg         upd_zn;
    reg         upd_dc;
    reg         c_new;
    reg         ov_new;
    reg         dc_new;
    wire [15:0] op_a;
    wire [15:0] op_b;
    wire [15:0] b_x;
    wire        is_sub;
    wire        cin;
    wire [16:0] sum16;
    wire [8:0]  sum8;
    wire [4:0]  sum4;
    wire        a_msb;
    wire        bx_msb;
    wire        res_msb;
    wire        res_zero;
    wire        issue;
    wire        gt7;
    wire        gt7_rise;
    wire        ctrl_wr;
    wire [33:0] mul_prod;
    wire        div_busy;
    wire        div_done;
    wire        div_dz;
    wire [15:0] div_quot;
    wire [15:0] div_rem;

    // ****************************************************************
    // Core control register
    // ****************************************************************
    assign gt7      = (i_cpu_prio > 4'h7);
    assign gt7_rise = gt7 & ~gt7_prev_q;
    assign ctrl_wr  = i_reg_wr && (i_reg_addr == `CXA_CORE_CTRL_ADDR);

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            prio7_q    <= 1'b0;
            gt7_prev_q <= 1'b0;
            pswin_q    <= 1'b0;
        end else begin
            gt7_prev_q <= gt7;
            // A rise in the same cycle as a software clear still sets
            if (gt7_rise) begin
                prio7_q <= 1'b1;
            end else if (!gt7) begin
                prio7_q <= 1'b0;
            end else if (ctrl_wr && !i_reg_wdata[`CXA_PRIO7_BIT]) begin
                prio7_q <= 1'b0;
            end
            if (ctrl_wr) begin
                pswin_q <= i_reg_wdata[`CXA_PSWIN_BIT];
            end
        end
    end

    assign o_priority_above_seven    = prio7_q;
    assign o_user_int_block          = prio7_q;
    assign o_program_space_window_en = pswin_q;

    // ****************************************************************
    // Register read port
    // ****************************************************************
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 16'h0000;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `CXA_CORE_CTRL_ADDR: begin
                    o_reg_rdata <= {12'h000, prio7_q, pswin_q, 2'b00};
                end
                `CXA_FLAGS_ADDR: begin
                    o_reg_rdata <= {11'h000, flags_q};
                end
                default: begin
                    o_reg_rdata <= 16'h0000;
                end
            endcase
        end else begin
            o_reg_rdata <= 16'h0000;
        end
    end

    // ****************************************************************
    // Operand selection and adder
    // ****************************************************************
    assign op_a = i_src_a_mem ? i_mem_rd : i_w_rd_a;
    assign op_b = i_src_b_mem ? i_mem_rd : i_w_rd_b;

    assign is_sub = (i_op_code == `CXA_OP_SUB) || (i_op_code == `CXA_OP_SUBB);
    assign b_x    = is_sub ? ~op_b : op_b;
    assign cin    = (i_op_code == `CXA_OP_SUB) ? 1'b1 :
                    ((i_op_code == `CXA_OP_ADDC) || (i_op_code == `CXA_OP_SUBB)) ?
                    flags_q[`CXA_FL_C] : 1'b0;

    assign sum16 = {1'b0, op_a} + {1'b0, b_x} + {16'h0000, cin};
    assign sum8  = {1'b0, op_a[7:0]} + {1'b0, b_x[7:0]} + {8'h00, cin};
    assign sum4  = {1'b0, op_a[3:0]} + {1'b0, b_x[3:0]} + {4'h0, cin};

    assign a_msb    = i_byte_mode ? op_a[7] : op_a[15];
    assign bx_msb   = i_byte_mode ? b_x[7] : b_x[15];
    assign res_msb  = i_byte_mode ? res_d[7] : res_d[15];
    assign res_zero = i_byte_mode ? (res_d[7:0] == 8'h00) : (res_d == 16'h0000);

    // ****************************************************************
    // ALU result and flag selection
    // ****************************************************************
    always @* begin
        res_d  = op_a;
        upd_c  = 1'b0;
        upd_ov = 1'b0;
        upd_zn = 1'b0;
        upd_dc = 1'b0;
        c_new  = 1'b0;
        ov_new = 1'b0;
        dc_new = 1'b0;
        case (i_op_code)
            `CXA_OP_ADD, `CXA_OP_ADDC, `CXA_OP_SUB, `CXA_OP_SUBB: begin
                res_d  = i_byte_mode ? {op_a[15:8], sum8[7:0]} : sum16[15:0];
                c_new  = i_byte_mode ? sum8[8] : sum16[16];
                dc_new = i_byte_mode ? sum4[4] : sum8[8];
                ov_new = (a_msb == bx_msb) && ((i_byte_mode ? sum8[7] : sum16[15]) != a_msb);
                upd_c  = 1'b1;
                upd_ov = 1'b1;
                upd_zn = 1'b1;
                upd_dc = 1'b1;
            end
            `CXA_OP_AND: begin
                res_d  = i_byte_mode ? {op_a[15:8], op_a[7:0] & op_b[7:0]} : (op_a & op_b);
                upd_zn = 1'b1;
            end
            `CXA_OP_IOR: begin
                res_d  = i_byte_mode ? {op_a[15:8], op_a[7:0] | op_b[7:0]} : (op_a | op_b);
                upd_zn = 1'b1;
            end
            `CXA_OP_XOR: begin
                res_d  = i_byte_mode ? {op_a[15:8], op_a[7:0] ^ op_b[7:0]} : (op_a ^ op_b);
                upd_zn = 1'b1;
            end
            `CXA_OP_COM: begin
                res_d  = i_byte_mode ? {op_a[15:8], ~op_a[7:0]} : ~op_a;
                upd_zn = 1'b1;
            end
            `CXA_OP_SL: begin
                res_d  = i_byte_mode ? {op_a[15:8], op_a[6:0], 1'b0} : {op_a[14:0], 1'b0};
                c_new  = a_msb;
                upd_c  = 1'b1;
                upd_zn = 1'b1;
            end
            `CXA_OP_LSR: begin
                res_d  = i_byte_mode ? {op_a[15:8], 1'b0, op_a[7:1]} : {1'b0, op_a[15:1]};
                c_new  = op_a[0];
                upd_c  = 1'b1;
                upd_zn = 1'b1;
            end
            `CXA_OP_ASR: begin
                res_d  = i_byte_mode ? {op_a[15:8], op_a[7], op_a[7:1]} :
                         {op_a[15], op_a[15:1]};
                c_new  = op_a[0];
                upd_c  = 1'b1;
                upd_zn = 1'b1;
            end
            default: begin
                res_d = op_a;
            end
        endcase
    end

    // ****************************************************************
    // Multiplier operand extension
    // ****************************************************************
    always @* begin
        case (i_mul_mode)
            `CXA_MUL_SS: begin
                mul_a = {op_a[15], op_a};
                mul_b = {op_b[15], op_b};
            end
            `CXA_MUL_UU: begin
                mul_a = {1'b0, op_a};
                mul_b = {1'b0, op_b};
            end
            `CXA_MUL_US: begin
                mul_a = {1'b0, op_a};
                mul_b = {op_b[15], op_b};
            end
            `CXA_MUL_SL5: begin
                mul_a = {op_a[15], op_a};
                mul_b = {12'h000, i_lit5};
            end
            `CXA_MUL_UL5: begin
                mul_a = {1'b0, op_a};
                mul_b = {12'h000, i_lit5};
            end
            `CXA_MUL_BYTE: begin
                mul_a = {9'h000, op_a[7:0]};
                mul_b = {9'h000, op_b[7:0]};
            end
            default: begin
                mul_a = {1'b0, op_a};
                mul_b = {1'b0, op_b};
            end
        endcase
    end

    cxa_mul17 u_mul (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_a        (mul_a),
        .i_b        (mul_b),
        .o_prod     (mul_prod)
    );

    // ****************************************************************
    // Divider
    // ****************************************************************
    cxa_div16 u_div (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_start    (issue && (i_op_code == `CXA_OP_DIV)),
        .i_signed   (i_div_signed),
        .i_dvd      (op_a),
        .i_dvs      (op_b),
        .o_busy     (div_busy),
        .o_done     (div_done),
        .o_dz       (div_dz),
        .o_quot     (div_quot),
        .o_rem      (div_rem)
    );

    // ****************************************************************
    // Issue, flags and result registers
    // ****************************************************************
    assign o_busy        = mul_pend_q | div_busy | div_done;
    assign issue         = i_op_valid & ~o_busy;
    assign o_arith_flags = flags_q;

    always @* begin
        flags_d = flags_q;
        if (i_reg_wr && (i_reg_addr == `CXA_FLAGS_ADDR)) begin
            flags_d = i_reg_wdata[4:0];
        end
        // Hardware updates take priority over a software write
        if (issue) begin
            if (upd_c) begin
                flags_d[`CXA_FL_C] = c_new;
            end
            if (upd_ov) begin
                flags_d[`CXA_FL_OV] = ov_new;
            end
            if (upd_dc) begin
                flags_d[`CXA_FL_DC] = dc_new;
            end
            if (upd_zn) begin
                flags_d[`CXA_FL_Z] = res_zero;
                flags_d[`CXA_FL_N] = res_msb;
            end
        end
        if (div_done) begin
            flags_d[`CXA_FL_OV] = div_dz;
        end
    end

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            flags_q      <= `CXA_FLAGS_RST;
            mul_pend_q   <= 1'b0;
            dst_mem_q    <= 1'b0;
            o_res_valid  <= 1'b0;
            o_res_w_we   <= 1'b0;
            o_res_mem_we <= 1'b0;
            o_res_lo     <= 16'h0000;
            o_res_hi     <= 16'h0000;
        end else begin
            flags_q      <= flags_d;
            o_res_valid  <= 1'b0;
            o_res_w_we   <= 1'b0;
            o_res_mem_we <= 1'b0;
            mul_pend_q   <= 1'b0;
            if (issue) begin
                dst_mem_q <= i_dst_mem;
            end
            if (issue && (i_op_code == `CXA_OP_MUL)) begin
                mul_pend_q <= 1'b1;
            end else if (issue && (i_op_code != `CXA_OP_DIV)) begin
                o_res_valid  <= 1'b1;
                o_res_w_we   <= ~i_dst_mem;
                o_res_mem_we <= i_dst_mem;
                o_res_lo     <= res_d;
                o_res_hi     <= 16'h0000;
            end else if (mul_pend_q) begin
                o_res_valid  <= 1'b1;
                o_res_w_we   <= ~dst_mem_q;
                o_res_mem_we <= dst_mem_q;
                o_res_lo     <= mul_prod[15:0];
                o_res_hi     <= mul_prod[31:16];
            end else if (div_done) begin
                o_res_valid  <= 1'b1;
                o_res_w_we   <= ~dst_mem_q;
                o_res_mem_we <= dst_mem_q;
                o_res_lo     <= div_quot;
                o_res_hi     <= div_rem;
            end
        end
    end

endmodule

// *** tb/cxa_core_checker.sv ***
// Port assertions for the ALU core
`timescale 1ns/1ps
`include "cxa_regs.vh"
module cxa_core_checker (
    input wire        i_core_clk,
    input wire        i_rst_n,
    input wire [3:0]  i_reg_addr,
    input wire [15:0] i_reg_wdata,
    input wire        i_reg_wr,
    input wire        i_reg_rd,
    input wire [15:0] o_reg_rdata,
    input wire [3:0]  i_cpu_prio,
    input wire        o_priority_above_seven,
    input wire        o_user_int_block,
    input wire        o_program_space_window_en,
    input wire        i_op_valid,
    input wire [3:0]  i_op_code,
    input wire        i_byte_mode,
    input wire        i_dst_mem,
    input wire        o_busy,
    input wire        o_res_valid,
    input wire        o_res_w_we,
    input wire        o_res_mem_we,
    input wire [15:0] o_res_lo,
    input wire [4:0]  o_arith_flags
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    wire take = i_op_valid && !o_busy;
    wire ctl  = i_reg_addr == `CXA_CORE_CTRL_ADDR;
    wire alu  = take && i_op_code < `CXA_OP_MUL;
    wire bm   = i_byte_mode;
    a_prio_drop: assert property (!i_cpu_prio[3] |=> !o_priority_above_seven)
        else $error("level bit set at level 7 or below");
    a_prio_rise: assert property ($rose(i_cpu_prio[3]) |=> o_priority_above_seven)
        else $error("level bit missed a rise above 7");
    a_int_block: assert property (o_user_int_block == o_priority_above_seven)
        else $error("interrupt block differs from level bit");
    a_sw_clear: assert property (i_reg_wr && ctl && !i_reg_wdata[`CXA_PRIO7_BIT]
        && !$rose(i_cpu_prio[3]) |=> !o_priority_above_seven) else $error("clear write ignored");
    a_pswin_wr: assert property (i_reg_wr && ctl
        |=> o_program_space_window_en == $past(i_reg_wdata[`CXA_PSWIN_BIT]))
        else $error("window enable not written");
    a_pswin_hold: assert property (!(i_reg_wr && ctl) |=> $stable(o_program_space_window_en))
        else $error("window enable changed without write");
    a_ctrl_read: assert property (i_reg_rd && ctl |=> o_reg_rdata == {12'h000,
        $past(o_priority_above_seven), $past(o_program_space_window_en), 2'h0})
        else $error("control read data wrong");
    a_alu_lat: assert property (alu |=> o_res_valid && o_res_mem_we == $past(i_dst_mem))
        else $error("alu result late or wrong target");
    a_mul_lat: assert property (take && i_op_code == `CXA_OP_MUL
        |=> o_busy && !o_res_valid ##1 o_res_valid) else $error("product timing wrong");
    a_div_lat: assert property (take && i_op_code == `CXA_OP_DIV
        |=> (o_busy && !o_res_valid)[*8] ##11 o_res_valid) else $error("quotient timing wrong");
    a_one_dest: assert property (o_res_valid |-> o_res_w_we != o_res_mem_we)
        else $error("result not sent to exactly one target");
    a_zero_neg: assert property (alu |=> o_arith_flags[`CXA_FL_N] ==
        ($past(bm) ? o_res_lo[7] : o_res_lo[15]) && o_arith_flags[`CXA_FL_Z] ==
        ($past(bm) ? o_res_lo[7:0] == 8'h00 : o_res_lo == 16'h0000)) else $error("Z or N wrong");
    c_mem_dest: cover property (o_res_valid && o_res_mem_we);
    c_clear_hi: cover property (i_reg_wr && ctl && o_priority_above_seven);
    c_long_end: cover property ($fell(o_busy));
endmodule
bind cxa_core cxa_core_checker i_cxa_core_checker (.*);

// *** tb/cxa_cpu_model.sv ***
// Working registers and data memory facing the ALU core
`timescale 1ns/1ps
module cxa_cpu_model (
    input  wire        i_core_clk,
    input  wire [1:0]  i_sel_a,
    input  wire [1:0]  i_sel_b,
    input  wire [1:0]  i_sel_m,
    input  wire [1:0]  i_sel_d,
    input  wire        i_ld_w,
    input  wire        i_ld_m,
    input  wire [15:0] i_ld_dat,
    input  wire        i_res_w_we,
    input  wire        i_res_mem_we,
    input  wire [15:0] i_res,
    output wire [15:0] o_w_a,
    output wire [15:0] o_w_b,
    output wire [15:0] o_mem
);
    logic [15:0] w_q [0:3];
    logic [15:0] m_q [0:3];
    assign o_w_a = w_q[i_sel_a];
    assign o_w_b = w_q[i_sel_b];
    assign o_mem = m_q[i_sel_m];
    always @(posedge i_core_clk) begin
        if (i_ld_w || i_res_w_we) w_q[i_sel_d] <= i_ld_w ? i_ld_dat : i_res;
        if (i_ld_m || i_res_mem_we) m_q[i_sel_d] <= i_ld_m ? i_ld_dat : i_res;
    end
endmodule

// *** tb/cxa_core_tb_top.sv ***
// Self-checking bench for the ALU core
`timescale 1ns/1ps
`include "cxa_regs.vh"
`define CHK(nm, got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
    $display("BAD %s exp %h got %h", nm, (exp), (got)); end end
module cxa_core_tb_top;
    logic i_core_clk, i_rst_n, i_reg_wr, i_reg_rd, i_op_valid, i_byte_mode, i_div_signed;
    logic i_src_a_mem, i_src_b_mem, i_dst_mem, ldw, ldm;
    logic [3:0] i_reg_addr, i_cpu_prio, i_op_code;
    logic [2:0] i_mul_mode;
    logic [4:0] i_lit5;
    logic [1:0] sa, sb, sm, sd;
    logic [15:0] i_reg_wdata, ldd;
    wire [15:0] o_reg_rdata, i_w_rd_a, i_w_rd_b, i_mem_rd, o_res_lo, o_res_hi;
    wire [4:0] o_arith_flags;
    wire o_priority_above_seven, o_user_int_block, o_program_space_window_en;
    wire o_busy, o_res_valid, o_res_w_we, o_res_mem_we;
    int mismatches = 0, compares = 0, cyc = 0;
    cxa_core i_cxa_core (.*);
    cxa_cpu_model i_cxa_cpu_model (.i_core_clk, .i_sel_a(sa), .i_sel_b(sb), .i_sel_m(sm),
        .i_sel_d(sd), .i_ld_w(ldw), .i_ld_m(ldm), .i_ld_dat(ldd), .i_res_w_we(o_res_w_we),
        .i_res_mem_we(o_res_mem_we), .i_res(o_res_lo), .o_w_a(i_w_rd_a), .o_w_b(i_w_rd_b),
        .o_mem(i_mem_rd));
    always #2.5 i_core_clk = ~i_core_clk;
    task tally_and_finish;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ****************************************************************
    // Hang guard
    // ****************************************************************
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            $display("BAD timeout exp end got hang");
            tally_and_finish;
        end
    end
    task reg_wr(input [3:0] a, input [15:0] d);
        @(posedge i_core_clk);
        {i_reg_wr, i_reg_addr, i_reg_wdata} <= {1'b1, a, d};
        @(posedge i_core_clk);
        i_reg_wr <= 1'b0;
    endtask
    task reg_rd(input [3:0] a, input [15:0] e);
        @(posedge i_core_clk);
        {i_reg_rd, i_reg_addr} <= {1'b1, a};
        @(posedge i_core_clk);
        i_reg_rd <= 1'b0;
        #1 `CHK("rdata", o_reg_rdata, e)
    endtask
    task setp(input [3:0] p);
        @(posedge i_core_clk);
        i_cpu_prio <= p;
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask
    task ld(input m, input [1:0] ix, input [15:0] d);
        @(posedge i_core_clk);
        {ldw, ldm, sd, ldd} <= {!m, m, ix, d};
        @(posedge i_core_clk);
        {ldw, ldm} <= 2'h0;
    endtask
    task go(input [3:0] c, input [3:0] m, input [2:0] s, input [1:0] d);
        int n;
        @(posedge i_core_clk);
        {i_op_valid, i_op_code, i_byte_mode, i_mul_mode, i_div_signed} <= {1'b1, c, m, m[0]};
        {i_src_a_mem, i_src_b_mem, i_dst_mem, sd} <= {s, d};
        @(posedge i_core_clk);
        i_op_valid <= 1'b0;
        #1 n = 0;
        while (o_res_valid !== 1'b1 && n < 30) begin
            @(posedge i_core_clk);
            #1 n++;
        end
        `CHK("done", n < 30, 1'b1)
    endtask
    task chk(input [3:0] c, m, input [15:0] a, b, input [31:0] e, input [4:0] f, k);
        ld(1'b0, 2'h0, a);
        ld(1'b0, 2'h1, b);
        i_lit5 <= b[4:0];
        go(c, m, 3'h0, 2'h2);
        `CHK("result", {o_res_hi, o_res_lo}, e)
        `CHK("flags", o_arith_flags & k, f & k)
    endtask
    initial begin
        {i_core_clk, i_rst_n, i_reg_wr, i_reg_rd, i_op_valid, i_byte_mode, i_div_signed} = '0;
        {i_src_a_mem, i_src_b_mem, i_dst_mem, ldw, ldm, i_reg_addr, i_cpu_prio} = '0;
        {i_op_code, i_mul_mode, i_lit5, sa, sm, sd, i_reg_wdata, ldd} = '0;
        sb = 2'h1;
        repeat (5) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        reg_rd(4'h0, 16'h0000);
        reg_rd(4'h1, 16'h0000);
        reg_wr(4'h0, 16'hFFFF);
        reg_rd(4'h0, 16'h0004);
        `CHK("pswin", o_program_space_window_en, 1'b1)
        reg_rd(4'hF, 16'h0000);
        reg_wr(4'h0, 16'h0000);
        setp(4'h8);
        reg_rd(4'h0, 16'h0008);
        `CHK("block", o_user_int_block, 1'b1)
        reg_wr(4'h0, 16'h0000);
        reg_rd(4'h0, 16'h0000);
        setp(4'h7);
        setp(4'h9);
        `CHK("prio", o_priority_above_seven, 1'b1)
        setp(4'h7);
        `CHK("prio", o_priority_above_seven, 1'b0)
        $display("test control done");
        chk(4'h0, 4'h0, 16'h7FFF, 16'h0001, 32'h00008000, 5'h1C, 5'h1F);
        chk(4'h0, 4'h0, 16'hFFFF, 16'h0001, 32'h00000000, 5'h13, 5'h1F);
        chk(4'h1, 4'h0, 16'h0001, 16'h0001, 32'h00000003, 5'h00, 5'h1F);
        chk(4'h2, 4'h0, 16'h0000, 16'h0001, 32'h0000FFFF, 5'h08, 5'h1F);
        chk(4'h3, 4'h0, 16'h0005, 16'h0001, 32'h00000003, 5'h11, 5'h1F);
        chk(4'h2, 4'h0, 16'h8000, 16'h0001, 32'h00007FFF, 5'h05, 5'h1F);
        chk(4'h0, 4'h8, 16'h12FF, 16'h0001, 32'h00001200, 5'h13, 5'h1F);
        chk(4'h4, 4'h0, 16'hF0F0, 16'h0F0F, 32'h00000000, 5'h02, 5'h0A);
        chk(4'h5, 4'h0, 16'h8000, 16'h0001, 32'h00008001, 5'h08, 5'h0A);
        chk(4'h6, 4'h0, 16'hFFFF, 16'hFFFF, 32'h00000000, 5'h02, 5'h0A);
        chk(4'h7, 4'h0, 16'h00FF, 16'h0000, 32'h0000FF00, 5'h08, 5'h0A);
        chk(4'h8, 4'h0, 16'h8001, 16'h0001, 32'h00000002, 5'h01, 5'h0B);
        chk(4'h9, 4'h0, 16'h8001, 16'h0001, 32'h00004000, 5'h01, 5'h0B);
        chk(4'hA, 4'h0, 16'h8000, 16'h0001, 32'h0000C000, 5'h08, 5'h0B);
        $display("test alu done");
        chk(4'hB, 4'h0, 16'hFFFF, 16'h0002, 32'hFFFFFFFE, 5'h00, 5'h00);
        chk(4'hB, 4'h1, 16'hFFFF, 16'h0002, 32'h0001FFFE, 5'h00, 5'h00);
        chk(4'hB, 4'h2, 16'hFFFF, 16'hFFFF, 32'hFFFF0001, 5'h00, 5'h00);
        chk(4'hB, 4'h3, 16'hFFFE, 16'h001F, 32'hFFFFFFC2, 5'h00, 5'h00);
        chk(4'hB, 4'h4, 16'hFFFE, 16'h001F, 32'h001EFFC2, 5'h00, 5'h00);
        chk(4'hB, 4'h5, 16'h12FF, 16'h34FF, 32'h0000FE01, 5'h00, 5'h00);
        chk(4'hC, 4'h0, 16'h0064, 16'h0007, 32'h0002000E, 5'h00, 5'h04);
        chk(4'hC, 4'h1, 16'hFF9C, 16'h0007, 32'hFFFEFFF2, 5'h00, 5'h04);
        ld(1'b0, 2'h1, 16'h0000);
        go(4'hC, 4'h0, 3'h0, 2'h2);
        `CHK("divzero", o_arith_flags[`CXA_FL_OV], 1'b1)
        $display("test mul div done");
        ld(1'b1, 2'h0, 16'h0010);
        ld(1'b0, 2'h1, 16'h0003);
        go(4'h0, 4'h0, 3'h5, 2'h3);
        `CHK("memsum", o_res_lo, 16'h0013)
        ld(1'b0, 2'h0, 16'h0020);
        sm <= 2'h3;
        go(4'h2, 4'h0, 3'h2, 2'h2);
        sb <= 2'h2;
        @(posedge i_core_clk);
        #1 `CHK("wback", i_w_rd_b, 16'h000D)
        $display("test routing done");
        tally_and_finish;
    end
endmodule
